/* shared/smfc_pkg.sv */
// constants and types shared by the secure message fragment checker
package smfc_pkg;

  // apb register byte offsets
  localparam logic [7:0] SMFC_OFF_CTRL = 8'h00;
  localparam logic [7:0] SMFC_OFF_STATUS = 8'h04;
  localparam logic [7:0] SMFC_OFF_INT_CLR = 8'h08;
  localparam logic [7:0] SMFC_OFF_INT_EN = 8'h0C;
  localparam logic [7:0] SMFC_OFF_HDR = 8'h10;
  localparam logic [7:0] SMFC_OFF_CHECK = 8'h14;
  localparam logic [7:0] SMFC_OFF_MISSED = 8'h18;
  localparam logic [7:0] SMFC_OFF_CHARS = 8'h1C;

  // control register fields and reset values
  localparam int SMFC_CTRL_ENABLE_BIT = 0;
  localparam int SMFC_CTRL_NUMBER_BIT = 1;
  localparam int SMFC_CTRL_ROLL_LSB = 8;
  localparam logic SMFC_RST_ENABLE = 1'b1;
  localparam logic SMFC_RST_NUMBER = 1'b1;
  localparam logic [5:0] SMFC_RST_ROLLOVER = 6'h3F;
  localparam logic [4:0] SMFC_RST_INT_EN = 5'h00;

  // status / interrupt bit positions
  localparam int SMFC_ST_FRAG_DONE = 0;
  localparam int SMFC_ST_CKSUM_ERR = 1;
  localparam int SMFC_ST_SEQ_ERR = 2;
  localparam int SMFC_ST_MISSED = 3;
  localparam int SMFC_ST_MSG_DONE = 4;
  localparam int SMFC_ST_W = 5;

  // word layout
  localparam int SMFC_WORD_W = 21;
  localparam int SMFC_CHAR_W = 7;
  localparam int SMFC_CHARS_PER_WORD = 3;
  localparam int SMFC_GRP_LO_LSB = 0;
  localparam int SMFC_GRP_MID_LSB = 8;
  localparam int SMFC_GRP_HI_LSB = 16;
  localparam logic [20:0] SMFC_CHECK_MASK = 21'h0003FF;
  localparam logic [1:0] SMFC_FRAG_INIT = 2'h3;
  localparam logic [1:0] SMFC_FRAG_FIRST_CONT = 2'h0;
  localparam logic [6:0] SMFC_FILL_CHAR = 7'h03;

  // paging address slots tracked for numbering
  localparam int SMFC_ADDR_W = 2;
  localparam int SMFC_NUM_ADDR = 4;

  typedef logic [6:0] smfc_char_t;

  // first word of a fragment, msb first so it overlays the word directly
  typedef struct packed {
    logic [1:0] spare;
    logic [5:0] num;
    logic [1:0] frag;
    logic cont;
    logic [9:0] check;
  } smfc_hdr_s;

  // one received codeword with its framing
  typedef struct packed {
    logic first;
    logic last;
    logic [SMFC_ADDR_W-1:0] addr;
    logic retrieval;
    logic [SMFC_WORD_W-1:0] data;
  } smfc_word_s;

  // three characters of a text word, third in the top bits
  typedef struct packed {
    smfc_char_t third;
    smfc_char_t second;
    smfc_char_t first;
  } smfc_chars_s;

endpackage : smfc_pkg

/* core/smfc_checksum.sv */
// fragment check value accumulator
`timescale 1ns/1ps
module smfc_checksum
  import smfc_pkg::*;
(
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_reset,
  input wire logic i_clk_en,
  // word stream
  input wire logic i_clear,
  input wire logic i_add,
  input wire logic [SMFC_WORD_W-1:0] i_word,
  // check value including the current word
  output logic [9:0] o_check_next
);

  logic [9:0] sum;
  wire [9:0] base = i_clear ? 10'h000 : sum;
  wire [9:0] grp_lo = {2'h0, i_word[SMFC_GRP_MID_LSB-1:SMFC_GRP_LO_LSB]};
  wire [9:0] grp_mid = {2'h0, i_word[SMFC_GRP_HI_LSB-1:SMFC_GRP_MID_LSB]};
  wire [9:0] grp_hi = {5'h00, i_word[SMFC_WORD_W-1:SMFC_GRP_HI_LSB]};
  wire [9:0] next_sum = base + grp_lo + grp_mid + grp_hi;

  assign o_check_next = ~next_sum;

  always_ff @(posedge i_sys_clk)
  begin
    if (i_reset)
      sum <= 10'h000;
    else if (i_clk_en && i_add)
      sum <= next_sum;
  end

endmodule : smfc_checksum

/* core/smfc_char_unpack.sv */
// splits a text word into its three characters and flags fill characters
`timescale 1ns/1ps
module smfc_char_unpack
  import smfc_pkg::*;
(
  // text word
  input wire logic [SMFC_WORD_W-1:0] i_word,
  // characters and fill flags
  output smfc_chars_s o_chars,
  output logic [SMFC_CHARS_PER_WORD-1:0] o_fill
);

  assign o_chars = smfc_chars_s'(i_word);

  genvar g;
  generate
    for (g = 0; g < SMFC_CHARS_PER_WORD; g++)
    begin : g_fill
      wire smfc_char_t ch = i_word[g*SMFC_CHAR_W +: SMFC_CHAR_W];
      assign o_fill[g] = (ch == SMFC_FILL_CHAR);
    end
  endgenerate

endmodule : smfc_char_unpack

/* core/smfc_fragment_checker.sv */
// secure message fragment checker with apb registers
// Behaviour
// - the check sum starts at zero and adds every word of the fragment, header fields and fill included.
// - each word is added as three groups, bits 0-7, 8-15 and 16-20, each with its lowest bit as lsb.
// - the check value is the ones complement of the sum cut to ten bits and is compared to the received one.
// - a set continuation flag means more fragments follow; a clear one ends the message.
// - the first fragment carries number 11 and later ones count up by one modulo three.
// - after the first fragment the number never returns to 11, so it cycles 00, 01, 10.
// - a gap in message numbers of an address is flagged and the missing numbers are reported.
// - a message whose retrieval flag is 0 is left out of gap detection and leaves the expected number alone.
// - fragments are tied to their message by the message number, unique per address.
// - text is 7-bit characters starting at the first character of the second word.
// - the first word holds check 0-9, continuation 10, fragment 11-12, number 13-18, spare 19-20.
//
// Design decisions made here: the address map and register access over APB.
`timescale 1ns/1ps
module smfc_fragment_checker
  import smfc_pkg::*;
(
  // clock, reset, enable
  input wire logic i_sys_clk,
  input wire logic i_reset,
  input wire logic i_clk_en,
  // apb slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // received codeword stream
  input wire logic i_word_valid,
  input wire smfc_word_s i_word,
  // unpacked text
  output logic o_char_valid,
  output smfc_chars_s o_chars,
  output logic [SMFC_CHARS_PER_WORD-1:0] o_char_fill,
  // fragment results
  output logic o_frag_done,
  output logic o_frag_err,
  output logic o_msg_done,
  // interrupt
  output logic o_irq
);

  // control state
  logic ctrl_enable;
  logic ctrl_number;
  logic [5:0] ctrl_rollover;
  logic [SMFC_ST_W-1:0] int_en;
  logic [SMFC_ST_W-1:0] status;
  smfc_hdr_s hdr;
  logic [9:0] check_calc;
  logic frag_unreliable;
  logic [5:0] missed_first;
  logic [5:0] missed_count;

  // per address tracking
  logic [1:0] exp_frag [SMFC_NUM_ADDR];
  logic in_prog [SMFC_NUM_ADDR];
  logic [5:0] cur_num [SMFC_NUM_ADDR];
  logic [5:0] exp_num [SMFC_NUM_ADDR];
  logic num_known [SMFC_NUM_ADDR];

  // next fragment number, skipping the initial value
  function automatic logic [1:0] smfc_next_frag(input logic [1:0] f);
    logic [1:0] n;
    n = f + 2'h1;
    if (f == SMFC_FRAG_INIT || n == SMFC_FRAG_INIT)
      n = SMFC_FRAG_FIRST_CONT;
    return n;
  endfunction : smfc_next_frag

  // apb address match
  function automatic logic smfc_hit(input logic [7:0] addr, input logic [7:0] off);
    return addr == off;
  endfunction : smfc_hit

  // stream decode
  wire take = i_clk_en & i_word_valid & ctrl_enable;
  wire smfc_hdr_s word_hdr = smfc_hdr_s'(i_word.data);
  wire smfc_hdr_s cur_hdr = i_word.first ? word_hdr : hdr;
  wire [SMFC_ADDR_W-1:0] sel = i_word.addr;
  wire end_frag = take & i_word.last;
  wire text_word = take & ~i_word.first;
  // the received check field counts as zero in its own sum
  wire [SMFC_WORD_W-1:0] add_word = i_word.first ? (i_word.data & ~SMFC_CHECK_MASK) : i_word.data;
  wire [9:0] check_next;
  smfc_chars_s unpack_chars;
  wire [SMFC_CHARS_PER_WORD-1:0] unpack_fill;

  // the sum restarts on every header word
  smfc_checksum u_checksum (
    .i_sys_clk(i_sys_clk),
    .i_reset(i_reset),
    .i_clk_en(i_clk_en),
    .i_clear(i_word.first),
    .i_add(take),
    .i_word(add_word),
    .o_check_next(check_next)
  );

  smfc_char_unpack u_unpack (
    .i_word(i_word.data),
    .o_chars(unpack_chars),
    .o_fill(unpack_fill)
  );

  // fragment sequencing
  wire cks_err = check_next != cur_hdr.check;
  wire is_init = cur_hdr.frag == SMFC_FRAG_INIT;
  wire num_match = cur_hdr.num == cur_num[sel];
  // a continuation must belong to the same message and come in order
  wire cont_ok = in_prog[sel] & (cur_hdr.frag == exp_frag[sel]) & num_match;
  wire seq_err = ~is_init & ~cont_ok;
  wire good = end_frag & ~cks_err;

  // message numbering
  wire count_num = is_init & ctrl_number & i_word.retrieval;
  wire [5:0] exp_here = exp_num[sel];
  wire gap = num_known[sel] & (cur_hdr.num != exp_here);
  wire [6:0] modulus = {1'b0, ctrl_rollover} + 7'h01;
  // numbers skipped since the expected one, wrapped at the rollover
  wire [6:0] gap_wide = (cur_hdr.num >= exp_here) ? ({1'b0, cur_hdr.num} - {1'b0, exp_here})
    : ({1'b0, cur_hdr.num} + modulus - {1'b0, exp_here});
  // next expected number wraps to zero after the rollover
  wire [5:0] num_after = (cur_hdr.num >= ctrl_rollover) ? 6'h00 : cur_hdr.num + 6'h01;

  // events
  // each event sets its sticky status bit; three of them also leave as pulses
  wire [SMFC_ST_W-1:0] events;
  assign events[SMFC_ST_FRAG_DONE] = end_frag;
  assign events[SMFC_ST_CKSUM_ERR] = end_frag & cks_err;
  assign events[SMFC_ST_SEQ_ERR] = good & seq_err;
  assign events[SMFC_ST_MISSED] = good & count_num & gap;
  assign events[SMFC_ST_MSG_DONE] = good & ~seq_err & ~cur_hdr.cont;

  // apb decode
  // the access phase is answered once, in the cycle after it starts
  wire apb_access = i_clk_en & i_psel & i_penable & ~o_pready;
  wire apb_wr = i_clk_en & i_psel & i_penable & o_pready & i_pwrite;
  wire hit_ctrl = smfc_hit(i_paddr, SMFC_OFF_CTRL);
  wire hit_status = smfc_hit(i_paddr, SMFC_OFF_STATUS);
  wire hit_clr = smfc_hit(i_paddr, SMFC_OFF_INT_CLR);
  wire hit_en = smfc_hit(i_paddr, SMFC_OFF_INT_EN);
  wire hit_hdr = smfc_hit(i_paddr, SMFC_OFF_HDR);
  wire hit_check = smfc_hit(i_paddr, SMFC_OFF_CHECK);
  wire hit_missed = smfc_hit(i_paddr, SMFC_OFF_MISSED);
  wire hit_chars = smfc_hit(i_paddr, SMFC_OFF_CHARS);
  wire hit_any = hit_ctrl | hit_status | hit_clr | hit_en | hit_hdr | hit_check | hit_missed | hit_chars;
  wire [31:0] rd_ctrl = {18'h00000, ctrl_rollover, 6'h00, ctrl_number, ctrl_enable};
  wire [31:0] rd_hdr = {11'h000, hdr};
  wire [31:0] rd_check = {15'h0000, frag_unreliable, 6'h00, check_calc};
  wire [31:0] rd_missed = {18'h00000, missed_count, 2'h0, missed_first};
  wire [31:0] rd_chars = {8'h00, o_char_fill, o_chars};
  wire [31:0] rd_data = hit_ctrl ? rd_ctrl
    : hit_status ? {27'h0000000, status}
    : hit_en ? {27'h0000000, int_en}
    : hit_hdr ? rd_hdr
    : hit_check ? rd_check
    : hit_missed ? rd_missed
    : hit_chars ? rd_chars
    : 32'h00000000;
  wire [SMFC_ST_W-1:0] clr_bits = (apb_wr & hit_clr) ? i_pwdata[SMFC_ST_W-1:0] : '0;
  // a new event wins over a clear in the same cycle
  wire [SMFC_ST_W-1:0] next_status = (status & ~clr_bits) | (i_clk_en ? events : '0);
  // enables as they stand after this edge, so the interrupt never lags a write
  wire [SMFC_ST_W-1:0] next_int_en = (apb_wr & hit_en) ? i_pwdata[SMFC_ST_W-1:0] : int_en;

  // apb answer: one wait state, data and error ready with pready
  always_ff @(posedge i_sys_clk)
  begin
    if (i_reset)
    begin
      o_pready <= 1'b0;
      o_prdata <= 32'h00000000;
      o_pslverr <= 1'b0;
    end
    else if (i_clk_en)
    begin
      o_pready <= apb_access;
      o_prdata <= (apb_access & ~i_pwrite & ~hit_clr) ? rd_data : 32'h00000000;
      o_pslverr <= apb_access & ~hit_any;
    end
  end

  // control register
  always_ff @(posedge i_sys_clk)
  begin
    if (i_reset)
    begin
      ctrl_enable <= SMFC_RST_ENABLE;
      ctrl_number <= SMFC_RST_NUMBER;
      ctrl_rollover <= SMFC_RST_ROLLOVER;
    end
    else if (apb_wr & hit_ctrl)
    begin
      ctrl_enable <= i_pwdata[SMFC_CTRL_ENABLE_BIT];
      ctrl_number <= i_pwdata[SMFC_CTRL_NUMBER_BIT];
      ctrl_rollover <= i_pwdata[SMFC_CTRL_ROLL_LSB +: 6];
    end
  end

  // interrupt enables
  always_ff @(posedge i_sys_clk)
  begin
    if (i_reset)
      int_en <= SMFC_RST_INT_EN;
    else if (i_clk_en)
      int_en <= next_int_en;
  end

  // sticky status
  always_ff @(posedge i_sys_clk)
  begin
    if (i_reset)
      status <= '0;
    else if (i_clk_en)
      status <= next_status;
  end

  // level interrupt, high while an enabled status bit is set
  always_ff @(posedge i_sys_clk)
  begin
    if (i_reset)
      o_irq <= 1'b0;
    else if (i_clk_en)
      o_irq <= |(next_status & next_int_en);
  end

  // header capture and fragment result
  always_ff @(posedge i_sys_clk)
  begin
    if (i_reset)
    begin
      hdr <= '0;
      check_calc <= 10'h000;
      frag_unreliable <= 1'b0;
    end
    else if (take)
    begin
      if (i_word.first)
        hdr <= word_hdr;
      if (i_word.last)
      begin
        check_calc <= check_next;
        frag_unreliable <= cks_err;
      end
    end
  end

  // result pulses
  always_ff @(posedge i_sys_clk)
  begin
    if (i_reset)
    begin
      o_frag_done <= 1'b0;
      o_frag_err <= 1'b0;
      o_msg_done <= 1'b0;
    end
    else if (i_clk_en)
    begin
      o_frag_done <= events[SMFC_ST_FRAG_DONE];
      o_frag_err <= events[SMFC_ST_CKSUM_ERR];
      o_msg_done <= events[SMFC_ST_MSG_DONE];
    end
  end

  // text output, first word carries no characters
  always_ff @(posedge i_sys_clk)
  begin
    if (i_reset)
    begin
      o_char_valid <= 1'b0;
      o_chars <= '0;
      o_char_fill <= '0;
    end
    else if (i_clk_en)
    begin
      o_char_valid <= text_word;
      if (text_word)
      begin
        o_chars <= unpack_chars;
        o_char_fill <= unpack_fill;
      end
    end
  end

  // missed message report
  always_ff @(posedge i_sys_clk)
  begin
    if (i_reset)
    begin
      missed_first <= 6'h00;
      missed_count <= 6'h00;
    end
    else if (events[SMFC_ST_MISSED])
    begin
      missed_first <= exp_here;
      missed_count <= gap_wide[5:0];
    end
  end

  // per address sequence state; a bad check leaves tracking untouched
  always_ff @(posedge i_sys_clk)
  begin
    if (i_reset)
    begin
      for (int k = 0; k < SMFC_NUM_ADDR; k++)
      begin
        exp_frag[k] <= SMFC_FRAG_INIT;
        in_prog[k] <= 1'b0;
        cur_num[k] <= 6'h00;
        exp_num[k] <= 6'h00;
        num_known[k] <= 1'b0;
      end
    end
    else if (good)
    begin
      if (is_init | ~seq_err)
      begin
        in_prog[sel] <= cur_hdr.cont;
        exp_frag[sel] <= cur_hdr.cont ? smfc_next_frag(cur_hdr.frag) : SMFC_FRAG_INIT;
        cur_num[sel] <= cur_hdr.num;
      end
      // an out of order continuation abandons the message in progress
      else
        in_prog[sel] <= 1'b0;
      if (count_num)
      begin
        exp_num[sel] <= num_after;
        num_known[sel] <= 1'b1;
      end
    end
  end

endmodule : smfc_fragment_checker

/* tb/smfc_fc_props.sv */
// concurrent checks on the fragment checker ports
`timescale 1ns/1ps
module smfc_fc_props
  import smfc_pkg::*;
(
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_reset,
  input wire logic i_clk_en,
  // apb
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic o_pready,
  input wire logic o_pslverr,
  // stream and results
  input wire logic i_word_valid,
  input wire smfc_word_s i_word,
  input wire logic o_char_valid,
  input wire smfc_chars_s o_chars,
  input wire logic [SMFC_CHARS_PER_WORD-1:0] o_char_fill,
  input wire logic o_frag_done,
  input wire logic o_frag_err,
  input wire logic o_msg_done
);
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (i_reset);

  ready_wait_a: assert property (i_psel && i_penable && !o_pready |=> o_pready)
    else $error("pready not one cycle after access");
  ready_pulse_a: assert property (o_pready |=> !o_pready)
    else $error("pready longer than one cycle");
  err_with_ready_a: assert property (o_pslverr |-> o_pready)
    else $error("pslverr without pready");
  char_timing_a: assert property (i_clk_en && i_word_valid && !i_word.first |=>
    o_char_valid && o_chars == $past(i_word.data))
    else $error("text word not unpacked in place");
  fill_flag_a: assert property (o_char_valid |-> o_char_fill ==
    {o_chars.third == SMFC_FILL_CHAR, o_chars.second == SMFC_FILL_CHAR, o_chars.first == SMFC_FILL_CHAR})
    else $error("fill flags wrong");
  done_timing_a: assert property (i_clk_en && i_word_valid && i_word.last |=> o_frag_done)
    else $error("fragment end not reported");
  done_cause_a: assert property (o_frag_done |-> $past(i_word_valid) && $past(i_word.last))
    else $error("fragment end without last word");
  err_with_done_a: assert property (o_frag_err |-> o_frag_done)
    else $error("fragment error outside fragment end");
  msg_good_a: assert property (o_msg_done |-> o_frag_done && !o_frag_err)
    else $error("message done on bad fragment");
endmodule : smfc_fc_props

bind smfc_fragment_checker smfc_fc_props u_props (.i_sys_clk(i_sys_clk), .i_reset(i_reset), .i_clk_en(i_clk_en),
  .i_psel(i_psel), .i_penable(i_penable), .o_pready(o_pready), .o_pslverr(o_pslverr),
  .i_word_valid(i_word_valid), .i_word(i_word), .o_char_valid(o_char_valid), .o_chars(o_chars),
  .o_char_fill(o_char_fill), .o_frag_done(o_frag_done), .o_frag_err(o_frag_err), .o_msg_done(o_msg_done));

/* tb/smfc_enc_model.sv */
// encoder model that frames secure message fragments
`timescale 1ns/1ps
module smfc_enc_model
  import smfc_pkg::*;
(
  // clock
  input wire logic i_sys_clk,
  // codeword stream
  output logic o_word_valid,
  output smfc_word_s o_word
);
  logic [9:0] last_check;
  logic [20:0] last_txt;

  initial
  begin
    o_word_valid = 1'b0;
    o_word = '0;
    last_check = 10'h0;
    last_txt = 21'h0;
  end

  task automatic send(input logic [1:0] a, input logic r, input logic [5:0] n, input logic [1:0] f,
    input logic c, input int nw, input logic [20:0] txt, input logic bad);
    logic [20:0] w [$];
    logic [15:0] s;
    s = 16'h0;
    w.push_back({2'h0, n, f, c, 10'h0});
    for (int k = 0; k < nw; k++) // fragments stay far below 84 words
      w.push_back(k == nw - 1 ? {SMFC_FILL_CHAR, SMFC_FILL_CHAR, txt[6:0]} : txt + 21'(k));
    foreach (w[k])
      s += 16'(w[k][7:0]) + 16'(w[k][15:8]) + 16'(w[k][20:16]);
    last_check = ~s[9:0];
    w[0][9:0] = last_check ^ {9'h0, bad};
    last_txt = w[w.size() - 1];
    foreach (w[k])
    begin
      o_word_valid <= 1'b1;
      o_word <= {k == 0, k == w.size() - 1, a, r, w[k]};
      @(posedge i_sys_clk);
    end
    o_word_valid <= 1'b0;
    // released data shows the inverse, never the last word
    o_word.data <= ~w[w.size() - 1];
  endtask : send
endmodule : smfc_enc_model

/* tb/test_secure_message_fragment_checker.sv */
// self-checking bench for the fragment checker
`timescale 1ns/1ps
module test_secure_message_fragment_checker;
  import smfc_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic [31:0] q;
  logic pready, pslverr, e, wv, ferr, mdone, irq;
  logic ce = 1'b1;
  smfc_word_s wd;
  logic [1:0] fseq [5] = '{2'h3, 2'h0, 2'h1, 2'h2, 2'h0};
  int n_mismatch = 0;
  int compares = 0;
  int cyc = 0;
  int n_msg = 0;
  int n_err = 0;
  int seed = 32'h4AB2;

  always #25 clk = ~clk;

  smfc_enc_model enc (.i_sys_clk(clk), .o_word_valid(wv), .o_word(wd));
  smfc_fragment_checker DUT (.i_sys_clk(clk), .i_reset(rst), .i_clk_en(ce),
    .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
    .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .i_word_valid(wv), .i_word(wd),
    .o_char_valid(), .o_chars(), .o_char_fill(), .o_frag_done(), .o_frag_err(ferr),
    .o_msg_done(mdone), .o_irq(irq));

  task automatic complete_run();
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : complete_run

  always @(posedge clk)
  begin
    cyc++;
    if (mdone === 1'b1)
      n_msg++;
    if (ferr === 1'b1)
      n_err++;
    if (cyc == 20000)
    begin
      n_mismatch++;
      complete_run();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // header register as the encoder framed it, spare bits zero
  function automatic logic [31:0] hdr_word(input logic [5:0] n, input logic [1:0] f, input logic c,
    input logic [9:0] k);
    return {13'h0, n, f, c, k};
  endfunction : hdr_word

  // character register: fill flags above the last text word
  function automatic logic [31:0] exp_chars(input logic [20:0] w);
    return {8'h00, w[20:14] == SMFC_FILL_CHAR, w[13:7] == SMFC_FILL_CHAR, w[6:0] == SMFC_FILL_CHAR, w};
  endfunction : exp_chars

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb

  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk(q, x);
    chk({31'h0, e}, 32'h0);
  endtask : rd

  task automatic clr();
    apb(1'b1, SMFC_OFF_INT_CLR, 32'h1F);
    @(posedge clk);
  endtask : clr

  task automatic tx(input logic [1:0] a, input logic r, input logic [5:0] n, input logic [1:0] f,
    input logic c, input int nw, input logic bad);
    enc.send(a, r, n, f, c, nw, 21'($random(seed)), bad);
    repeat (4) @(posedge clk);
  endtask : tx

  initial
  begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd(SMFC_OFF_CTRL, 32'h3F03);
    rd(SMFC_OFF_INT_EN, 32'h0);
    rd(SMFC_OFF_STATUS, 32'h0);
    apb(1'b0, 8'h20, 32'h0);
    chk({31'h0, e}, 32'h1);
    chk(q, 32'h0);
    $display("test reset done");
    for (int i = 0; i < 6; i++)
    begin
      tx(2'h2, 1'b0, 6'(i), SMFC_FRAG_INIT, 1'b0, 1 + ($random(seed) & 7), 1'b0);
      rd(SMFC_OFF_CHECK, {22'h0, enc.last_check});
      rd(SMFC_OFF_CHARS, exp_chars(enc.last_txt));
      rd(SMFC_OFF_STATUS, 32'h11);
      clr();
    end
    chk(32'(n_msg), 32'h6);
    $display("test check value done");
    tx(2'h2, 1'b0, 6'h7, SMFC_FRAG_INIT, 1'b0, 2, 1'b1);
    rd(SMFC_OFF_CHECK, {15'h0, 1'b1, 6'h0, enc.last_check});
    rd(SMFC_OFF_STATUS, 32'h3);
    chk(32'(n_err), 32'h1);
    clr();
    $display("test bad check done");
    foreach (fseq[k])
      tx(2'h0, 1'b0, 6'h5, fseq[k], k < 4, 1, 1'b0);
    rd(SMFC_OFF_STATUS, 32'h11);
    rd(SMFC_OFF_HDR, hdr_word(6'h5, 2'h0, 1'b0, enc.last_check));
    chk(32'(n_msg), 32'h7);
    clr();
    tx(2'h0, 1'b0, 6'h6, SMFC_FRAG_INIT, 1'b1, 1, 1'b0);
    tx(2'h0, 1'b0, 6'h6, 2'h1, 1'b0, 1, 1'b0);
    rd(SMFC_OFF_STATUS, 32'h5);
    chk(32'(n_msg), 32'h7);
    clr();
    $display("test fragments done");
    tx(2'h1, 1'b1, 6'h0, SMFC_FRAG_INIT, 1'b0, 1, 1'b0);
    tx(2'h1, 1'b1, 6'h3, SMFC_FRAG_INIT, 1'b0, 1, 1'b0);
    rd(SMFC_OFF_STATUS, 32'h19);
    rd(SMFC_OFF_MISSED, 32'h0201);
    clr();
    tx(2'h1, 1'b0, 6'h9, SMFC_FRAG_INIT, 1'b0, 1, 1'b0);
    tx(2'h1, 1'b1, 6'h4, SMFC_FRAG_INIT, 1'b0, 1, 1'b0);
    rd(SMFC_OFF_STATUS, 32'h11);
    clr();
    $display("test numbering done");
    apb(1'b1, SMFC_OFF_INT_EN, 32'h2);
    tx(2'h3, 1'b0, 6'h1, SMFC_FRAG_INIT, 1'b0, 3, 1'b1);
    chk({31'h0, irq}, 32'h1);
    clr();
    chk({31'h0, irq}, 32'h0);
    apb(1'b1, SMFC_OFF_INT_EN, 32'h0);
    tx(2'h3, 1'b0, 6'h2, SMFC_FRAG_INIT, 1'b0, 3, 1'b1);
    chk({31'h0, irq}, 32'h0);
    apb(1'b1, SMFC_OFF_STATUS, 32'h1F);
    rd(SMFC_OFF_STATUS, 32'h3);
    $display("test interrupt done");
    clr();
    ce <= 1'b0;
    tx(2'h3, 1'b0, 6'h3, SMFC_FRAG_INIT, 1'b0, 2, 1'b1);
    ce <= 1'b1;
    rd(SMFC_OFF_STATUS, 32'h0);
    apb(1'b1, SMFC_OFF_CTRL, 32'h0303);
    rd(SMFC_OFF_CTRL, 32'h0303);
    tx(2'h3, 1'b1, 6'h2, SMFC_FRAG_INIT, 1'b0, 1, 1'b0);
    tx(2'h3, 1'b1, 6'h1, SMFC_FRAG_INIT, 1'b0, 1, 1'b0);
    rd(SMFC_OFF_STATUS, 32'h19);
    rd(SMFC_OFF_MISSED, 32'h0203);
    clr();
    apb(1'b1, SMFC_OFF_CTRL, 32'h0301);
    tx(2'h3, 1'b1, 6'h0, SMFC_FRAG_INIT, 1'b0, 1, 1'b0);
    rd(SMFC_OFF_STATUS, 32'h11);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd(SMFC_OFF_CTRL, 32'h3F03);
    rd(SMFC_OFF_STATUS, 32'h0);
    $display("test control done");
    complete_run();
  end
endmodule : test_secure_message_fragment_checker
